// file: usb_irq_enable_priority.sv
/*
 * Interrupt enable and four-level priority controller with APB registers,
 * sticky event status, fixed within-level order and nested service tracking.
 * Assumes APB on ref_clk_i and a core that acks one vector and signals return.
 */
// Our own choices: the register addresses and the APB register port.
// What this block does
// - Bit 7 of the USB enable register enables the keyboard scan interrupt and masks it when clear.
// - A keyboard scan event is requested only when both its enable and the scan enable are set.
// - Bit 1 enables the function endpoint transmit and receive done interrupts.
// - Bit 0 enables the shared hub and start-of-frame interrupt.
// - Every source has its own level chosen from four by a high and a low priority bit.
// - The high bit is the upper bit of the level, so 00 is lowest and 11 highest.
// - A running handler is preempted by any pending request of a strictly higher level.
// - Requests of equal or lower level never preempt, so a level 3 handler is never preempted.
// - Among pending requests the highest level is vectored first.
// - Equal-level requests sampled in one four-state cycle are treated as simultaneous.
// - Ties go in the fixed order ext0, timer0, ext1, timer1, serial, timer2, keyscan, slot 7, hub, function, suspend.
// - The global enable gates every vectored interrupt, the USB ones included, but not the status line irq_o.
module usb_irq_enable_priority
   import irq_prio_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Interrupt sources, one-cycle events
   input  wire logic [10:0] src_event_i,
   // Core vectoring
   output logic             vec_req_o,
   output logic [3:0]       vec_id_o,
   output logic [1:0]       vec_level_o,
   input  wire logic        vec_ack_i,
   input  wire logic        reti_i,
   // Status interrupt line
   output logic             irq_o
);

   arb_if arb ();

   logic [7:0]  base_en;
   logic [7:0]  usb_keyscan_irq_enable;
   logic [7:0]  prio_high_bits_a;
   logic [7:0]  prio_low_bits_a;
   logic [7:0]  prio_high_bits_b;
   logic [7:0]  prio_low_bits_b;
   logic [7:0]  keyboard_control_reg;
   logic [10:0] status;
   logic [10:0] irq_mask;
   logic [3:0]  in_service;
   logic [1:0]  sample_cnt;
   logic        sample_en;
   logic [10:0] src_en;
   logic [10:0] src_req;
   logic [21:0] src_lvl;
   logic [10:0] ack_clr;
   logic        wr_en;
   logic        rd_setup;
   logic        addr_ok;
   logic        any_service;
   logic [1:0]  cur_level;
   logic [31:0] next_rdata;

   function automatic logic [1:0] make_level(input logic hi, input logic lo);
      make_level = {hi, lo};
   endfunction : make_level

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_BASE_EN) || (a == OFS_USB_EN) || (a == OFS_PRIO_HA) ||
               (a == OFS_PRIO_LA) || (a == OFS_PRIO_HB) || (a == OFS_PRIO_LB) ||
               (a == OFS_KBD_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK) ||
               (a == OFS_SERVICE);
   endfunction : mapped

   wire logic global_irq_enable           = base_en[GLOBAL_EN_BIT];
   wire logic keyscan_irq_en              = usb_keyscan_irq_enable[KEYSCAN_EN_BIT];
   wire logic suspend_resume_reset_irq_en = usb_keyscan_irq_enable[SUSPEND_EN_BIT];
   wire logic function_endpoint_irq_en    = usb_keyscan_irq_enable[FUNCTION_EN_BIT];
   wire logic hub_frame_irq_en            = usb_keyscan_irq_enable[HUB_FRAME_EN_BIT];
   wire logic keyscan_enable              = keyboard_control_reg[KBD_SCAN_EN_BIT];

   // APB decode; zero wait states
   assign wr_en     = psel_i && penable_i && pwrite_i;
   assign rd_setup  = psel_i && !penable_i && !pwrite_i;
   assign addr_ok   = mapped(paddr_i);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;

   // Per-slot enables
   always_comb
   begin
      src_en                = 11'h000;
      src_en[SLOT_EXT0]     = base_en[0];
      src_en[SLOT_TMR0]     = base_en[1];
      src_en[SLOT_EXT1]     = base_en[2];
      src_en[SLOT_TMR1]     = base_en[3];
      src_en[SLOT_SERIAL]   = base_en[4];
      src_en[SLOT_TMR2]     = base_en[5];
      src_en[SLOT_KEYSCAN]  = keyscan_irq_en && keyscan_enable;
      src_en[SLOT_HUB]      = hub_frame_irq_en;
      src_en[SLOT_FUNC]     = function_endpoint_irq_en;
      src_en[SLOT_SUSP]     = suspend_resume_reset_irq_en;
   end

   assign src_req = status & src_en & {NUM_SLOTS{global_irq_enable}};

   // Per-slot levels from the two priority register pairs
   always_comb
   begin
      src_lvl = 22'h000000;
      for (int i = 0; i < 6; i++)
      begin
         src_lvl[2*i +: 2] = make_level(prio_high_bits_a[i], prio_low_bits_a[i]);
      end
      src_lvl[2*SLOT_KEYSCAN +: 2] = make_level(prio_high_bits_b[KEYSCAN_EN_BIT],
                                                prio_low_bits_b[KEYSCAN_EN_BIT]);
      src_lvl[2*SLOT_HUB +: 2]     = make_level(prio_high_bits_b[HUB_FRAME_EN_BIT],
                                                prio_low_bits_b[HUB_FRAME_EN_BIT]);
      src_lvl[2*SLOT_FUNC +: 2]    = make_level(prio_high_bits_b[FUNCTION_EN_BIT],
                                                prio_low_bits_b[FUNCTION_EN_BIT]);
      src_lvl[2*SLOT_SUSP +: 2]    = make_level(prio_high_bits_b[SUSPEND_EN_BIT],
                                                prio_low_bits_b[SUSPEND_EN_BIT]);
   end

   assign arb.req = src_req;
   assign arb.lvl = src_lvl;

   prio_resolver u_resolver
   (
      .arb (arb)
   );

   // Four-state sampling divider
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         sample_cnt <= 2'h0;
      else
         sample_cnt <= sample_cnt + 2'h1;
   end

   assign sample_en = (sample_cnt == 2'(SAMPLE_STATES - 1));

   // Enable and control registers
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         base_en                <= BASE_EN_RST;
         usb_keyscan_irq_enable <= USB_EN_RST;
         prio_high_bits_a       <= PRIO_RST;
         prio_low_bits_a        <= PRIO_RST;
         prio_high_bits_b       <= PRIO_RST;
         prio_low_bits_b        <= PRIO_RST;
         keyboard_control_reg   <= KBD_RST;
         irq_mask               <= MASK_RST;
      end
      else if (wr_en)
      begin
         unique case (paddr_i)
            OFS_BASE_EN:  base_en                <= pwdata_i[7:0] & BASE_EN_WMASK;
            OFS_USB_EN:   usb_keyscan_irq_enable <= pwdata_i[7:0] & USB_EN_WMASK;
            OFS_PRIO_HA:  prio_high_bits_a       <= pwdata_i[7:0] & PRIO_A_WMASK;
            OFS_PRIO_LA:  prio_low_bits_a        <= pwdata_i[7:0] & PRIO_A_WMASK;
            OFS_PRIO_HB:  prio_high_bits_b       <= pwdata_i[7:0] & PRIO_B_WMASK;
            OFS_PRIO_LB:  prio_low_bits_b        <= pwdata_i[7:0] & PRIO_B_WMASK;
            OFS_KBD_CTRL: keyboard_control_reg   <= pwdata_i[7:0] & KBD_WMASK;
            OFS_MASK:     irq_mask               <= pwdata_i[10:0];
            default:      ;
         endcase
      end
   end

   // Sticky event status: new events win over write-one clears and vector clears
   always_comb
   begin
      ack_clr = 11'h000;
      if (vec_req_o && vec_ack_i)
         ack_clr[vec_id_o] = 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         status <= STATUS_RST;
      else if (wr_en && paddr_i == OFS_STATUS)
         status <= (status & ~pwdata_i[10:0] & ~ack_clr) | (src_event_i & ~11'(1 << SLOT_UNUSED));
      else
         status <= (status & ~ack_clr) | (src_event_i & ~11'(1 << SLOT_UNUSED));
   end

   assign irq_o = |(status & irq_mask);

   // Service nesting: one bit per level in service
   always_comb
   begin
      any_service = |in_service;
      cur_level   = 2'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (in_service[l])
            cur_level = 2'(l);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         in_service <= 4'h0;
      else if (vec_req_o && vec_ack_i)
         in_service[vec_level_o] <= 1'b1;
      else if (reti_i && any_service)
         in_service[cur_level] <= 1'b0;
   end

   // Vector request, re-evaluated once per sampling cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         vec_req_o   <= 1'b0;
         vec_id_o    <= 4'h0;
         vec_level_o <= 2'h0;
      end
      else if (vec_req_o && vec_ack_i)
         vec_req_o <= 1'b0;
      else if (sample_en)
      begin
         // Preempt only for a strictly higher level
         vec_req_o   <= arb.found && (!any_service || arb.win_lvl > cur_level);
         vec_id_o    <= arb.win_id;
         vec_level_o <= arb.win_lvl;
      end
   end

   // Read data, captured in the setup cycle
   always_comb
   begin
      next_rdata = 32'h00000000;
      unique case (paddr_i)
         OFS_BASE_EN:  next_rdata[7:0]  = base_en;
         OFS_USB_EN:   next_rdata[7:0]  = usb_keyscan_irq_enable;
         OFS_PRIO_HA:  next_rdata[7:0]  = prio_high_bits_a;
         OFS_PRIO_LA:  next_rdata[7:0]  = prio_low_bits_a;
         OFS_PRIO_HB:  next_rdata[7:0]  = prio_high_bits_b;
         OFS_PRIO_LB:  next_rdata[7:0]  = prio_low_bits_b;
         OFS_KBD_CTRL: next_rdata[7:0]  = keyboard_control_reg;
         OFS_STATUS:   next_rdata[10:0] = status;
         OFS_MASK:     next_rdata[10:0] = irq_mask;
         OFS_SERVICE:  next_rdata[11:0] = {vec_level_o, vec_id_o, vec_req_o, any_service, in_service};
         default:      next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         prdata_o <= 32'h00000000;
      else if (rd_setup)
         prdata_o <= next_rdata;
   end

   // Checks
   sequence s_sample_win;
      sample_en && arb.found && !(vec_req_o && vec_ack_i);
   endsequence

   sequence s_taken;
      vec_req_o && vec_ack_i;
   endsequence

   property p_keyscan_mask;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !usb_keyscan_irq_enable[KEYSCAN_EN_BIT] |-> !src_req[SLOT_KEYSCAN];
   endproperty
   a_keyscan_mask: assert property (p_keyscan_mask) else $error("keyscan requested while masked");

   property p_keyscan_gate;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      src_req[SLOT_KEYSCAN] |-> keyscan_enable && keyscan_irq_en && status[SLOT_KEYSCAN];
   endproperty
   a_keyscan_gate: assert property (p_keyscan_gate) else $error("keyscan requested without scan enable");

   property p_usb_enables;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (src_req[SLOT_SUSP] |-> usb_keyscan_irq_enable[SUSPEND_EN_BIT]) and
      (src_req[SLOT_FUNC] |-> usb_keyscan_irq_enable[FUNCTION_EN_BIT]);
   endproperty
   a_usb_enables: assert property (p_usb_enables) else $error("usb source requested while disabled");

   property p_hub_enable;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      src_req[SLOT_HUB] |-> usb_keyscan_irq_enable[HUB_FRAME_EN_BIT];
   endproperty
   a_hub_enable: assert property (p_hub_enable) else $error("hub source requested while disabled");

   property p_global_gate;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !global_irq_enable |-> src_req == 11'h000;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("request with global enable clear");

   property p_reset_zero;
      @(posedge ref_clk_i)
      !nrst_i |=> usb_keyscan_irq_enable == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("usb enable not cleared by reset");

   property p_preempt;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_sample_win ##0 (!any_service || arb.win_lvl > cur_level)
         |=> vec_req_o && vec_level_o == $past(arb.win_lvl) && vec_id_o == $past(arb.win_id);
   endproperty
   a_preempt: assert property (p_preempt) else $error("higher level request not vectored");

   property p_no_preempt;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      vec_req_o |-> !any_service || vec_level_o > cur_level;
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("equal or lower level preempted");

   property p_nest;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_taken |=> in_service[$past(vec_level_o)] && !vec_req_o;
   endproperty
   a_nest: assert property (p_nest) else $error("taken vector not recorded");

   property p_sampled;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      $changed(vec_id_o) |-> $past(sample_en);
   endproperty
   a_sampled: assert property (p_sampled) else $error("vector changed outside sampling edge");

endmodule : usb_irq_enable_priority

// file: irq_prio_pkg.sv
/*
 * Shared constants for the interrupt enable and priority block:
 * register offsets, field positions, reset values and source slots.
 * Assumes a 32-bit APB master and a core that takes one vector at a time.
 */
package irq_prio_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_BASE_EN   = 8'h00;
   localparam logic [7:0] OFS_USB_EN    = 8'h04;
   localparam logic [7:0] OFS_PRIO_HA   = 8'h08;
   localparam logic [7:0] OFS_PRIO_LA   = 8'h0c;
   localparam logic [7:0] OFS_PRIO_HB   = 8'h10;
   localparam logic [7:0] OFS_PRIO_LB   = 8'h14;
   localparam logic [7:0] OFS_KBD_CTRL  = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h1c;
   localparam logic [7:0] OFS_MASK      = 8'h20;
   localparam logic [7:0] OFS_SERVICE   = 8'h24;

   // Field positions
   localparam int GLOBAL_EN_BIT   = 7;
   localparam int KEYSCAN_EN_BIT  = 7;
   localparam int SUSPEND_EN_BIT  = 2;
   localparam int FUNCTION_EN_BIT = 1;
   localparam int HUB_FRAME_EN_BIT = 0;
   localparam int KBD_SCAN_EN_BIT = 0;

   // Writable bits of each register; the rest read as zero
   localparam logic [7:0] BASE_EN_WMASK = 8'hbf;
   localparam logic [7:0] USB_EN_WMASK  = 8'h87;
   localparam logic [7:0] PRIO_A_WMASK  = 8'h3f;
   localparam logic [7:0] PRIO_B_WMASK  = 8'h87;
   localparam logic [7:0] KBD_WMASK     = 8'h01;

   // Reset values
   localparam logic [7:0]  BASE_EN_RST = 8'h00;
   localparam logic [7:0]  USB_EN_RST  = 8'h00;
   localparam logic [7:0]  PRIO_RST    = 8'h00;
   localparam logic [7:0]  KBD_RST     = 8'h00;
   localparam logic [10:0] STATUS_RST  = 11'h000;
   localparam logic [10:0] MASK_RST    = 11'h000;

   // Source slots in fixed within-level order, slot 0 wins ties
   localparam int NUM_SLOTS   = 11;
   localparam int SLOT_EXT0   = 0;
   localparam int SLOT_TMR0   = 1;
   localparam int SLOT_EXT1   = 2;
   localparam int SLOT_TMR1   = 3;
   localparam int SLOT_SERIAL = 4;
   localparam int SLOT_TMR2   = 5;
   localparam int SLOT_KEYSCAN = 6;
   localparam int SLOT_UNUSED = 7;
   localparam int SLOT_HUB    = 8;
   localparam int SLOT_FUNC   = 9;
   localparam int SLOT_SUSP   = 10;

   // Sampling cycle: four states, one clock each
   localparam int SAMPLE_STATES = 4;

endpackage : irq_prio_pkg

// file: arb_if.sv
/*
 * Carrier between the controller and its priority resolver.
 * Assumes both ends sit on the same clock.
 */
interface arb_if;
   logic [10:0] req;
   logic [21:0] lvl;
   logic        found;
   logic [3:0]  win_id;
   logic [1:0]  win_lvl;

   modport resolver (input req, input lvl, output found, output win_id, output win_lvl);
   modport client   (output req, output lvl, input found, input win_id, input win_lvl);
endinterface : arb_if

// file: prio_resolver.sv
/*
 * Combinational priority resolver: highest level wins, ties go to the
 * lowest slot number. Assumes unused slots are never requested.
 */
module prio_resolver
   import irq_prio_pkg::*;
(
   // Request side
   arb_if.resolver arb
);

   always_comb
   begin
      arb.found   = 1'b0;
      arb.win_id  = 4'h0;
      arb.win_lvl = 2'h0;
      // Walk from the last slot down so a tie keeps the earlier slot
      for (int i = NUM_SLOTS - 1; i >= 0; i--)
      begin
         if (arb.req[i] && (!arb.found || arb.lvl[2*i +: 2] >= arb.win_lvl))
         begin
            arb.found   = 1'b1;
            arb.win_id  = 4'(i);
            arb.win_lvl = arb.lvl[2*i +: 2];
         end
      end
   end

endmodule : prio_resolver

// file: core_model.sv
/*
 * Model of the processor core's vectoring side: takes a vector after a
 * programmable wait and returns from handlers when the bench asks.
 * Assumes the controller's vector outputs are registered on clk_i.
 */
module core_model
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Controller side
   input  wire logic       vec_req_i,
   input  wire logic [3:0] vec_id_i,
   input  wire logic [1:0] vec_level_i,
   output logic            vec_ack_o,
   output logic            reti_o,
   // Bench side
   input  var  int         ack_wait_i,
   input  wire logic       ret_now_i,
   output logic [3:0]      took_id_o,
   output logic [1:0]      took_lvl_o,
   output int              n_taken_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int cnt;
   int depth;

   // A return is only issued while some handler is in progress
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         vec_ack_o <= 1'b0;
         reti_o    <= 1'b0;
         cnt       <= 0;
         depth     <= 0;
         n_taken_o <= 0;
      end
      else
      begin
         reti_o <= ret_now_i && depth != 0 && !reti_o;
         depth  <= depth + (vec_ack_o && vec_req_i ? 1 : 0) - (reti_o ? 1 : 0);
         if (vec_ack_o)
         begin
            vec_ack_o <= 1'b0;
            cnt       <= 0;
            if (vec_req_i)
            begin
               took_id_o  <= vec_id_i;
               took_lvl_o <= vec_level_i;
               n_taken_o  <= n_taken_o + 1;
            end
         end
         else if (vec_req_i)
         begin
            if (cnt >= ack_wait_i)
               vec_ack_o <= 1'b1;
            else
               cnt <= cnt + 1;
         end
         else
            cnt <= 0;
      end
   end
endmodule : core_model

// file: usb_irq_enable_priority_tb.sv
/*
 * Self-checking bench for the interrupt enable and priority block.
 * Assumes core_model answers vectors and irq_prio_pkg gives the map.
 */
module usb_irq_enable_priority_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_prio_pkg::*;

   logic        ref_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [10:0] src_event_i;
   logic        vec_req_o, vec_ack_i, reti_i, irq_o, ret_now, err;
   logic [3:0]  vec_id_o, took_id;
   logic [1:0]  vec_level_o, took_lvl;
   int          ack_wait, n_taken, miscompares, n_tests;

   usb_irq_enable_priority DUT (.ref_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .src_event_i, .vec_req_o, .vec_id_o,
      .vec_level_o, .vec_ack_i, .reti_i, .irq_o);
   core_model core (.clk_i(ref_clk_i), .nrst_i(nrst_i), .vec_req_i(vec_req_o), .vec_id_i(vec_id_o),
      .vec_level_i(vec_level_o), .vec_ack_o(vec_ack_i), .reti_o(reti_i), .ack_wait_i(ack_wait),
      .ret_now_i(ret_now), .took_id_o(took_id), .took_lvl_o(took_lvl), .n_taken_o(n_taken));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   task results;
      $display("mismatches %0d of %0d checks", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      // The wait ends once pready_o is high; only a wait where it never rises is ended by the watchdog
      do
      begin
         @(posedge ref_clk_i);
      end
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task fire(input logic [10:0] m);
      @(posedge ref_clk_i);
      src_event_i <= m;
      @(posedge ref_clk_i);
      src_event_i <= 11'h000;
      @(posedge ref_clk_i);
   endtask : fire

   task take(input logic [3:0] id, input logic [1:0] lv);
      int n0;
      int k;
      n0 = n_taken;
      for (k = 0; k < 80 && n_taken == n0; k++)
         @(posedge ref_clk_i);
      chk(32'(n_taken - n0), 32'd1, "vector taken");
      chk(took_id, id, "vector id");
      chk(took_lvl, lv, "vector level");
   endtask : take

   task none;
      logic hit;
      hit = 1'b0;
      repeat (16)
      begin
         @(posedge ref_clk_i);
         if (vec_req_o !== 1'b0)
            hit = 1'b1;
      end
      chk(hit, 1'b0, "unexpected vector request");
   endtask : none

   task ret;
      @(posedge ref_clk_i);
      ret_now <= 1'b1;
      @(posedge ref_clk_i);
      ret_now <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
   endtask : ret

   task t_regs;
      apb(1'b0, OFS_USB_EN, 32'h0);
      chk(rd, 32'h0, "usb enable reset");
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1, "unmapped read error");
      chk(rd, 32'h0, "unmapped read data");
      apb(1'b1, OFS_USB_EN, 32'h87);
      apb(1'b0, OFS_USB_EN, 32'h0);
      chk(rd, 32'h87, "usb enable readback");
      apb(1'b1, OFS_USB_EN, 32'h0);
   endtask : t_regs

   task t_usb_en;
      int slot[4] = '{6, 8, 9, 10};
      int bpos[4] = '{7, 0, 1, 2};
      apb(1'b1, OFS_BASE_EN, 32'h80);
      apb(1'b1, OFS_KBD_CTRL, 32'h1);
      apb(1'b1, OFS_PRIO_HB, 32'h87);
      apb(1'b1, OFS_PRIO_LB, 32'h87);
      for (int i = 0; i < 4; i++)
      begin
         fire(11'h1 << slot[i]);
         none();
         apb(1'b1, OFS_USB_EN, 32'h1 << bpos[i]);
         take(slot[i][3:0], 2'd3);
         ret();
      end
      apb(1'b1, OFS_KBD_CTRL, 32'h0);
      apb(1'b1, OFS_USB_EN, 32'h80);
      fire(11'h040);
      none();
      apb(1'b1, OFS_KBD_CTRL, 32'h1);
      take(4'd6, 2'd3);
      ret();
      apb(1'b1, OFS_BASE_EN, 32'h0);
      apb(1'b1, OFS_USB_EN, 32'h02);
      fire(11'h200);
      none();
      apb(1'b1, OFS_BASE_EN, 32'h80);
      take(4'd9, 2'd3);
      ret();
      apb(1'b1, OFS_PRIO_HB, 32'h0);
      apb(1'b1, OFS_PRIO_LB, 32'h0);
   endtask : t_usb_en

   task t_levels;
      logic [1:0] hi;
      logic [1:0] lo;
      apb(1'b1, OFS_BASE_EN, 32'hbf);
      for (int lv = 1; lv < 4; lv++)
      begin
         hi = 2'(lv);
         lo = 2'(lv - 1);
         apb(1'b1, OFS_PRIO_HA, {26'h0, hi[1], 4'h0, lo[1]});
         apb(1'b1, OFS_PRIO_LA, {26'h0, hi[0], 4'h0, lo[0]});
         fire(11'h021);
         take(4'd5, hi);
         ret();
         take(4'd0, lo);
         ret();
      end
   endtask : t_levels

   task t_ties;
      int order[10] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10};
      apb(1'b1, OFS_PRIO_HA, 32'h0);
      apb(1'b1, OFS_PRIO_LA, 32'h0);
      apb(1'b1, OFS_USB_EN, 32'h87);
      ack_wait <= 5;
      fire(11'h77f);
      for (int i = 0; i < 10; i++)
      begin
         take(order[i][3:0], 2'd0);
         ret();
      end
      ack_wait <= 0;
   endtask : t_ties

   task t_preempt;
      apb(1'b1, OFS_PRIO_HA, 32'h1c);
      apb(1'b1, OFS_PRIO_LA, 32'h1b);
      fire(11'h001);
      take(4'd0, 2'd1);
      fire(11'h002);
      none();
      fire(11'h004);
      take(4'd2, 2'd2);
      fire(11'h008);
      take(4'd3, 2'd3);
      fire(11'h010);
      none();
      apb(1'b1, OFS_STATUS, 32'h7ff);
      repeat (4) ret();
   endtask : t_preempt

   task t_irq;
      apb(1'b1, OFS_BASE_EN, 32'h0);
      apb(1'b1, OFS_MASK, 32'h200);
      fire(11'h600);
      chk(irq_o, 1'b1, "status interrupt raised");
      apb(1'b1, OFS_STATUS, 32'h200);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(irq_o, 1'b0, "status interrupt cleared");
      chk(rd, 32'h400, "masked status bit kept");
      apb(1'b1, OFS_STATUS, 32'h400);
   endtask : t_irq

   initial
   begin
      nrst_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      src_event_i = 11'h000;
      ret_now = 1'b0;
      ack_wait = 0;
      miscompares = 0;
      n_tests = 0;
      repeat (3) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      t_regs();
      t_usb_en();
      t_levels();
      t_ties();
      t_preempt();
      t_irq();
      results();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (30000) @(posedge ref_clk_i);
      miscompares++;
      results();
   end
endmodule : usb_irq_enable_priority_tb
